// >>> low_power_request_decoder.sv
`timescale 1ns/10ps
module low_power_request_decoder
(
  input  wire logic        clk_in,
  input  wire logic        reset_in,
  input  wire logic        clk_en_in,
  input  wire logic        byte_valid_in,
  input  wire logic [7:0]  byte_in,
  input  wire logic        frame_start_in,
  input  wire logic        frame_end_in,
  input  wire logic        asleep_in,
  input  wire logic        msg_pending_in,
  output logic             reduced_power_out,
  output logic             on_demand_fix_mode_out,
  output logic [23:0]      wake_period_out,
  output logic [15:0]      search_timeout_out,
  output logic [15:0]      retry_sleep_out,
  output logic [15:0]      receiver_on_window_out,
  output logic             request_applied_out,
  output logic             request_refused_out,
  output logic             msg_send_enable_out,
  output logic             notice_send_ok_out,
  output logic             notice_withhold_out,
  output logic [23:0]      uart_bps_out,
  output logic [3:0]       uart_data_bits_out,
  output logic             uart_parity_out,
  output logic             uart_two_stop_out,
  output logic [23:0]      twi_kbps_out,
  output logic             twi_multi_master_out,
  output logic [15:0]      spi_max_khz_out
);
  typedef enum {IDLE, COLLECT, SKIP, ROUND, COMMIT} state_t;

  state_t      state;
  state_t      next_state;
  logic [5:0]  pos;
  logic [5:0]  next_pos;
  logic [7:0]  sel;
  logic [7:0]  next_sel;
  logic [23:0] rate;
  logic [23:0] next_rate;
  logic [15:0] mask;
  logic [15:0] next_mask;
  logic [15:0] search;
  logic [15:0] next_search;
  logic [15:0] off;
  logic [15:0] next_off;
  logic [15:0] on_win;
  logic [15:0] next_on_win;
  logic [23:0] step;
  logic [23:0] rounded;
  logic [23:0] srch_r;
  logic [23:0] off_r;

  // asleep state comes from the power sequencer pins, so synchronise
  logic        sleep_meta;
  logic        sleep_sync;
  logic        sleep_prev;

  logic        reduced_power;
  logic        next_reduced_power;
  logic        on_demand;
  logic        next_on_demand;
  logic [23:0] wake;
  logic [23:0] next_wake;
  logic [15:0] search_t;
  logic [15:0] next_search_t;
  logic [15:0] retry_t;
  logic [15:0] next_retry_t;
  logic [15:0] on_t;
  logic [15:0] next_on_t;
  logic        applied;
  logic        next_applied;
  logic        refused;
  logic        next_refused;

  logic        demand_sel;
  assign demand_sel = mask[lpr_pkg::MASK_DEMAND_BIT];

  always_comb
  begin
    if (rate < lpr_pkg::FINE_LIMIT)
    begin
      step = lpr_pkg::FINE_STEP;
    end
    else
    begin
      step = lpr_pkg::COARSE_STEP;
    end
  end

  lpr_round u_rate_round
  (
    .clk_in      (clk_in),
    .reset_in    (reset_in),
    .enable_in   (clk_en_in),
    .value_in    ((rate > lpr_pkg::RATE_MAX) ? lpr_pkg::RATE_MAX : rate),
    .step_in     ((rate == 24'h000000) ? 24'h000000 : step),
    .rounded_out (rounded)
  );

  lpr_round u_search_round
  (
    .clk_in      (clk_in),
    .reset_in    (reset_in),
    .enable_in   (clk_en_in),
    .value_in    ({8'h00, search}),
    .step_in     (demand_sel ? lpr_pkg::COARSE_STEP : 24'h000000),
    .rounded_out (srch_r)
  );

  lpr_round u_off_round
  (
    .clk_in      (clk_in),
    .reset_in    (reset_in),
    .enable_in   (clk_en_in),
    .value_in    ({8'h00, off}),
    .step_in     (demand_sel ? lpr_pkg::COARSE_STEP : 24'h000000),
    .rounded_out (off_r)
  );

  // byte collector
  always_comb
  begin
    next_state  = state;
    next_pos    = pos;
    next_sel    = sel;
    next_rate   = rate;
    next_mask   = mask;
    next_search = search;
    next_off    = off;
    next_on_win = on_win;
    if (frame_start_in)
    begin
      next_state = COLLECT;
      next_pos   = 6'h00;
    end
    else
    begin
      case (state)
        IDLE:
        begin
          next_state = IDLE;
        end
        COLLECT:
        begin
          if (byte_valid_in)
          begin
            next_pos = pos + 6'h01;
            if ((pos == 6'h00 && byte_in != lpr_pkg::MSG_ID) ||
                (pos == 6'h01 && byte_in != lpr_pkg::MSG_SUB_ID))
            begin
              next_state = SKIP;
            end
            // fields shift in high byte first
            case (pos)
              lpr_pkg::POS_SELECT:    next_sel = byte_in;
              lpr_pkg::POS_RATE_UP:   next_rate = {byte_in, 16'h0000};
              lpr_pkg::POS_RATE_HI:   next_rate = {rate[23:16], byte_in, 8'h00};
              lpr_pkg::POS_RATE_LO:   next_rate = {rate[23:8], byte_in};
              lpr_pkg::POS_MASK_HI:   next_mask = {byte_in, 8'h00};
              lpr_pkg::POS_MASK_LO:   next_mask = {mask[15:8], byte_in};
              lpr_pkg::POS_SEARCH_HI: next_search = {byte_in, 8'h00};
              lpr_pkg::POS_SEARCH_LO: next_search = {search[15:8], byte_in};
              lpr_pkg::POS_OFF_HI:    next_off = {byte_in, 8'h00};
              lpr_pkg::POS_OFF_LO:    next_off = {off[15:8], byte_in};
              lpr_pkg::POS_ON_HI:     next_on_win = {byte_in, 8'h00};
              lpr_pkg::POS_ON_LO:     next_on_win = {on_win[15:8], byte_in};
              default:                next_pos = pos + 6'h01;
            endcase
            // short frames are dropped; reserved bytes are not checked
            if (pos == lpr_pkg::POS_LAST && frame_end_in)
            begin
              next_state = ROUND;
            end
          end
          else if (frame_end_in)
          begin
            next_state = IDLE;
          end
        end
        SKIP:
        begin
          if (frame_end_in)
          begin
            next_state = IDLE;
          end
        end
        ROUND:
        begin
          next_state = COMMIT;
        end
        COMMIT:
        begin
          next_state = IDLE;
        end
        default:
        begin
          next_state = IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      state  <= IDLE;
      pos    <= 6'h00;
      sel    <= 8'h00;
      rate   <= 24'h000000;
      mask   <= 16'h0000;
      search <= 16'h0000;
      off    <= 16'h0000;
      on_win <= 16'h0000;
    end
    else if (clk_en_in)
    begin
      state  <= next_state;
      pos    <= next_pos;
      sel    <= next_sel;
      rate   <= next_rate;
      mask   <= next_mask;
      search <= next_search;
      off    <= next_off;
      on_win <= next_on_win;
    end
  end

  // configuration, volatile, back to defaults on reset
  always_comb
  begin
    next_reduced_power = reduced_power;
    next_on_demand     = on_demand;
    next_wake          = wake;
    next_search_t      = search_t;
    next_retry_t       = retry_t;
    next_on_t          = on_t;
    next_applied       = 1'b0;
    next_refused       = 1'b0;
    if (state == COMMIT)
    begin
      if (sleep_sync || sel > lpr_pkg::SELECT_REDUCED)
      begin
        next_refused = 1'b1;
      end
      else
      begin
        next_applied       = 1'b1;
        next_reduced_power = (sel == lpr_pkg::SELECT_REDUCED);
        if (mask[lpr_pkg::MASK_APPLY_BIT])
        begin
          next_on_demand = demand_sel;
          next_wake      = demand_sel ? {8'h00, lpr_pkg::DEMAND_PERIOD} : rounded;
          next_search_t  = srch_r[15:0];
          next_retry_t   = off_r[15:0];
          if (on_win < lpr_pkg::ON_MIN)
          begin
            next_on_t = lpr_pkg::ON_MIN;
          end
          else if (on_win > lpr_pkg::ON_MAX)
          begin
            next_on_t = lpr_pkg::ON_MAX;
          end
          else
          begin
            next_on_t = ((on_win + (lpr_pkg::ON_STEP >> 1)) / lpr_pkg::ON_STEP) * lpr_pkg::ON_STEP;
          end
        end
      end
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      reduced_power <= 1'b0;
      on_demand     <= 1'b0;
      wake          <= {8'h00, lpr_pkg::DEF_RATE};
      search_t      <= lpr_pkg::DEF_SEARCH;
      retry_t       <= lpr_pkg::DEF_OFF;
      on_t          <= lpr_pkg::DEF_ON_WINDOW;
      applied       <= 1'b0;
      refused       <= 1'b0;
    end
    else if (clk_en_in)
    begin
      reduced_power <= next_reduced_power;
      on_demand     <= next_on_demand;
      wake          <= next_wake;
      search_t      <= next_search_t;
      retry_t       <= next_retry_t;
      on_t          <= next_on_t;
      applied       <= next_applied;
      refused       <= next_refused;
    end
  end

  // power state tracking and notices
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      sleep_meta          <= 1'b0;
      sleep_sync          <= 1'b0;
      sleep_prev          <= 1'b0;
      msg_send_enable_out <= 1'b0;
      notice_send_ok_out  <= 1'b0;
      notice_withhold_out <= 1'b0;
    end
    else if (clk_en_in)
    begin
      sleep_meta          <= asleep_in;
      sleep_sync          <= sleep_meta;
      sleep_prev          <= sleep_sync;
      msg_send_enable_out <= msg_pending_in && !sleep_sync;
      notice_send_ok_out  <= sleep_prev && !sleep_sync;
      notice_withhold_out <= !sleep_prev && sleep_sync;
    end
  end

  always_comb
  begin
    reduced_power_out      = reduced_power;
    on_demand_fix_mode_out = on_demand;
    wake_period_out        = wake;
    search_timeout_out     = search_t;
    retry_sleep_out        = retry_t;
    receiver_on_window_out = on_t;
    request_applied_out    = applied;
    request_refused_out    = refused;
    uart_bps_out           = lpr_pkg::UART_DEF_BPS;
    uart_data_bits_out     = lpr_pkg::UART_DEF_BITS;
    uart_parity_out        = 1'b0;
    uart_two_stop_out      = 1'b0;
    twi_kbps_out           = lpr_pkg::TWI_DEF_KBPS;
    twi_multi_master_out   = 1'b1;
    spi_max_khz_out        = lpr_pkg::SPI_DEF_KHZ;
  end

  chk_withhold_on_sleep: assert property (@(posedge clk_in) disable iff (reset_in)
    clk_en_in && !sleep_prev && sleep_sync ##1 clk_en_in |-> notice_withhold_out)
    else $error("withhold notice missing");
  chk_ok_on_wake: assert property (@(posedge clk_in) disable iff (reset_in)
    clk_en_in && sleep_prev && !sleep_sync |=> notice_send_ok_out && !sleep_prev)
    else $error("send notice missing on wake");
  chk_quiet_asleep: assert property (@(posedge clk_in) disable iff (reset_in)
    clk_en_in && sleep_sync ##1 clk_en_in |-> !msg_send_enable_out)
    else $error("message while asleep");
  chk_refuse_asleep: assert property (@(posedge clk_in) disable iff (reset_in)
    clk_en_in && state == COMMIT && sleep_sync |=> !applied && $stable(wake))
    else $error("applied while asleep");
  chk_on_window_range: assert property (@(posedge clk_in) disable iff (reset_in)
    on_t >= lpr_pkg::ON_MIN && on_t <= lpr_pkg::ON_MAX && on_t % lpr_pkg::ON_STEP == 16'h0000)
    else $error("on window out of range");
  chk_demand_period: assert property (@(posedge clk_in) disable iff (reset_in)
    $rose(applied) && on_demand |-> wake == {8'h00, lpr_pkg::DEMAND_PERIOD})
    else $error("demand period wrong");
  chk_defaults_kept: assert property (@(posedge clk_in) disable iff (reset_in)
    clk_en_in && state == COMMIT && !mask[0] |=> $stable(search_t) && $stable(on_t))
    else $error("defaults changed");
  chk_demand_round: assert property (@(posedge clk_in) disable iff (reset_in)
    $rose(applied) && on_demand |-> retry_t % 16'h001E == 16'h0000)
    else $error("retry not rounded");
  cov_applied: cover property (@(posedge clk_in) applied && reduced_power);
  cov_refused: cover property (@(posedge clk_in) refused);
  cov_notice: cover property (@(posedge clk_in) notice_send_ok_out);
endmodule

// >>> lpr_pkg.sv
package lpr_pkg;
  localparam logic [7:0]  MSG_ID           = 8'hDA;
  localparam logic [7:0]  MSG_SUB_ID       = 8'h06;
  localparam int          MSG_LEN          = 42;
  // byte positions in the payload, counted from the identifier byte
  localparam logic [5:0]  POS_SELECT       = 6'h02;
  localparam logic [5:0]  POS_RATE_UP      = 6'h05;
  localparam logic [5:0]  POS_RATE_HI      = 6'h06;
  localparam logic [5:0]  POS_RATE_LO      = 6'h07;
  localparam logic [5:0]  POS_MASK_HI      = 6'h08;
  localparam logic [5:0]  POS_MASK_LO      = 6'h09;
  localparam logic [5:0]  POS_SEARCH_HI    = 6'h0A;
  localparam logic [5:0]  POS_SEARCH_LO    = 6'h0B;
  localparam logic [5:0]  POS_OFF_HI       = 6'h0C;
  localparam logic [5:0]  POS_OFF_LO       = 6'h0D;
  localparam logic [5:0]  POS_ON_HI        = 6'h14;
  localparam logic [5:0]  POS_ON_LO        = 6'h15;
  localparam logic [5:0]  POS_LAST         = 6'h29;
  localparam int          MASK_APPLY_BIT   = 0;
  localparam int          MASK_DEMAND_BIT  = 2;
  localparam logic [7:0]  SELECT_FULL      = 8'h00;
  localparam logic [7:0]  SELECT_REDUCED   = 8'h01;
  localparam logic [23:0] FINE_LIMIT       = 24'h00001E;
  localparam logic [23:0] RATE_MAX         = 24'h015180;
  localparam logic [23:0] FINE_STEP        = 24'h000006;
  localparam logic [23:0] COARSE_STEP      = 24'h00001E;
  localparam logic [15:0] DEMAND_PERIOD    = 16'h0006;
  localparam logic [15:0] DEF_RATE         = 16'h0001;
  localparam logic [15:0] DEF_SEARCH       = 16'h0078;
  localparam logic [15:0] DEF_OFF          = 16'h001E;
  localparam logic [15:0] DEF_ON_WINDOW    = 16'h00C8;
  localparam logic [15:0] ON_MIN           = 16'h0064;
  localparam logic [15:0] ON_MAX           = 16'h0320;
  localparam logic [15:0] ON_STEP          = 16'h0064;
  localparam logic [23:0] UART_DEF_BPS     = 24'h0012C0;
  localparam logic [3:0]  UART_DEF_BITS    = 4'h8;
  localparam logic [23:0] TWI_DEF_KBPS     = 24'h000190;
  localparam logic [15:0] SPI_DEF_KHZ      = 16'h1A90;
endpackage

// >>> lpr_round.sv
`timescale 1ns/10ps
// rounds a value to nearest multiple of step; registered output
module lpr_round
(
  input  wire logic        clk_in,
  input  wire logic        reset_in,
  input  wire logic        enable_in,
  input  wire logic [23:0] value_in,
  input  wire logic [23:0] step_in,
  output logic      [23:0] rounded_out
);
  logic [23:0] next_rounded;
  logic [23:0] low;
  logic [23:0] rem;

  always_comb
  begin
    rem = (step_in == 24'h000000) ? 24'h000000 : value_in % step_in;
    low = value_in - rem;
    next_rounded = low;
    if (step_in != 24'h000000 && (rem << 1) >= step_in)
    begin
      next_rounded = low + step_in;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      rounded_out <= 24'h000000;
    end
    else if (enable_in)
    begin
      rounded_out <= next_rounded;
    end
  end
endmodule

// >>> host_frame_source.sv
`timescale 1ns/10ps
// host side of the request link: one byte a cycle behind a start pulse
module host_frame_source
(
  input  wire logic       clk_in,
  output logic            byte_valid_out,
  output logic [7:0]      byte_out,
  output logic            frame_start_out,
  output logic            frame_end_out
);
  initial
  begin
    byte_valid_out  = 1'b0;
    byte_out        = 8'h00;
    frame_start_out = 1'b0;
    frame_end_out   = 1'b0;
  end

  // n below 42 abandons the frame part way; bad_id spoils the sub-identifier
  task automatic send_request(input logic [7:0] sel, input logic [23:0] rate, input logic [15:0] mask,
                              input logic [15:0] srch, input logic [15:0] off, input logic [15:0] on,
                              input int n, input bit bad_id);
    logic [7:0] f [42];
    f = '{default: 8'h00};
    f[0] = 8'hDA;
    f[1] = bad_id ? 8'h07 : 8'h06;
    f[2] = sel;
    f[5] = rate[23:16];
    f[6] = rate[15:8];
    f[7] = rate[7:0];
    f[9] = mask[7:0] & 8'h05;
    f[10] = srch[15:8];
    f[11] = srch[7:0];
    f[12] = off[15:8];
    f[13] = off[7:0];
    f[20] = on[15:8];
    f[21] = on[7:0];
    @(posedge clk_in);
    frame_start_out <= 1'b1;
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk_in);
      frame_start_out <= 1'b0;
      byte_valid_out  <= 1'b1;
      byte_out        <= f[i];
      frame_end_out   <= (i == 41);
    end
    @(posedge clk_in);
    byte_valid_out <= 1'b0;
    frame_end_out  <= 1'b0;
    // released data line shows the inverse so a stale byte cannot pass as valid
    byte_out       <= ~f[n-1];
  endtask
endmodule

// >>> testbench.sv
`timescale 1ns/10ps
module testbench;
  logic        clk_in   = 1'b0;
  logic        reset_in = 1'b1;
  logic        asleep   = 1'b0;
  logic        pending  = 1'b0;
  logic        clk_en   = 1'b1;
  logic        byte_valid;
  logic [7:0]  byte_data;
  logic        frame_start;
  logic        frame_end;
  logic        reduced_power_out;
  logic        on_demand_fix_mode_out;
  logic [23:0] wake_period_out;
  logic [15:0] search_timeout_out;
  logic [15:0] retry_sleep_out;
  logic [15:0] receiver_on_window_out;
  logic        request_applied_out;
  logic        request_refused_out;
  logic        msg_send_enable_out;
  logic        notice_send_ok_out;
  logic        notice_withhold_out;
  logic [23:0] uart_bps_out;
  logic [3:0]  uart_data_bits_out;
  logic        uart_parity_out;
  logic        uart_two_stop_out;
  logic [23:0] twi_kbps_out;
  logic        twi_multi_master_out;
  logic [15:0] spi_max_khz_out;
  int          n_mismatch  = 0;
  int          check_count = 0;
  int          n_app = 0;
  int          n_ref = 0;
  int          n_ok  = 0;
  int          n_wh  = 0;
  int          cycles = 0;
  logic        e_red;
  logic        e_dem;
  logic [23:0] e_wake;
  logic [15:0] e_srch;
  logic [15:0] e_off;
  logic [15:0] e_on;
  logic [23:0] rates [10] = '{24'h000000, 24'h000002, 24'h000003, 24'h00001D, 24'h00001E,
                              24'h00002C, 24'h00002D, 24'h015180, 24'h015181, 24'hFFFFFF};
  logic [15:0] ons [10]   = '{16'h0000, 16'h0095, 16'h0096, 16'h0320, 16'h0384,
                              16'hFFFF, 16'h0064, 16'h02ED, 16'h02EE, 16'h00C8};

  always #2 clk_in = ~clk_in;

  host_frame_source host_frame_source_i
  (
    .clk_in          (clk_in),
    .byte_valid_out  (byte_valid),
    .byte_out        (byte_data),
    .frame_start_out (frame_start),
    .frame_end_out   (frame_end)
  );

  low_power_request_decoder low_power_request_decoder_i
  (
    .clk_in                 (clk_in),
    .reset_in               (reset_in),
    .clk_en_in              (clk_en),
    .byte_valid_in          (byte_valid),
    .byte_in                (byte_data),
    .frame_start_in         (frame_start),
    .frame_end_in           (frame_end),
    .asleep_in              (asleep),
    .msg_pending_in         (pending),
    .reduced_power_out      (reduced_power_out),
    .on_demand_fix_mode_out (on_demand_fix_mode_out),
    .wake_period_out        (wake_period_out),
    .search_timeout_out     (search_timeout_out),
    .retry_sleep_out        (retry_sleep_out),
    .receiver_on_window_out (receiver_on_window_out),
    .request_applied_out    (request_applied_out),
    .request_refused_out    (request_refused_out),
    .msg_send_enable_out    (msg_send_enable_out),
    .notice_send_ok_out     (notice_send_ok_out),
    .notice_withhold_out    (notice_withhold_out),
    .uart_bps_out           (uart_bps_out),
    .uart_data_bits_out     (uart_data_bits_out),
    .uart_parity_out        (uart_parity_out),
    .uart_two_stop_out      (uart_two_stop_out),
    .twi_kbps_out           (twi_kbps_out),
    .twi_multi_master_out   (twi_multi_master_out),
    .spi_max_khz_out        (spi_max_khz_out)
  );

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // pulses are counted here so a one-cycle answer is never missed
  always @(posedge clk_in)
  begin
    cycles++;
    n_app += (request_applied_out === 1'b1);
    n_ref += (request_refused_out === 1'b1);
    n_ok  += (notice_send_ok_out === 1'b1);
    n_wh  += (notice_withhold_out === 1'b1);
    if (cycles == 20000)
    begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  task automatic check_value(input logic [31:0] seen, input logic [31:0] expected);
    check_count++;
    if (seen !== expected)
    begin
      n_mismatch++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, expected);
    end
  endtask

  function automatic logic [23:0] rnd(input logic [23:0] v, input logic [23:0] s);
    return ((v + s / 2) / s) * s;
  endfunction

  function automatic logic [23:0] rate_exp(input logic [23:0] r);
    if (r < 24'h00001E)
      return rnd(r, 24'h000006);
    if (r > 24'h015180)
      return 24'h015180;
    return rnd(r, 24'h00001E);
  endfunction

  function automatic logic [15:0] on_exp(input logic [15:0] v);
    if (v < 16'h0064)
      return 16'h0064;
    if (v > 16'h0320)
      return 16'h0320;
    return 16'(rnd({8'h00, v}, 24'h000064));
  endfunction

  function automatic logic [23:0] rand_rate;
    int k;
    k = $urandom % 3;
    if (k == 0)
      return 24'($urandom % 30);
    if (k == 1)
      return 24'(30 + $urandom % 86371);
    return 24'(86401 + $urandom % 100000);
  endfunction

  task automatic check_state(input bit chk_wake);
    check_value(reduced_power_out, e_red);
    check_value(on_demand_fix_mode_out, e_dem);
    if (chk_wake)
      check_value(wake_period_out, e_wake);
    check_value(search_timeout_out, e_srch);
    check_value(retry_sleep_out, e_off);
    check_value(receiver_on_window_out, e_on);
  endtask

  task automatic wait_answer(input int a0, input int r0);
    for (int i = 0; i < 10 && n_app == a0 && n_ref == r0; i++)
    begin
      @(posedge clk_in);
      #1;
    end
  endtask

  task automatic apply(input logic [7:0] sel, input logic [23:0] rate, input logic [15:0] mask,
                       input logic [15:0] srch, input logic [15:0] off, input logic [15:0] on, input bit ok);
    int a0;
    int r0;
    a0 = n_app;
    r0 = n_ref;
    host_frame_source_i.send_request(sel, rate, mask, srch, off, on, 42, 1'b0);
    wait_answer(a0, r0);
    check_value(n_app - a0, ok);
    check_value(n_ref - r0, !ok);
    if (ok)
    begin
      e_red = sel[0];
      if (mask[0])
      begin
        e_dem  = mask[2];
        e_wake = mask[2] ? 24'h000006 : rate_exp(rate);
        e_srch = mask[2] ? 16'(rnd({8'h00, srch}, 24'h00001E)) : srch;
        e_off  = mask[2] ? 16'(rnd({8'h00, off}, 24'h00001E)) : off;
        e_on   = on_exp(on);
      end
    end
    check_state(1'b1);
  endtask

  // frames that must draw no answer at all
  task automatic send_dud(input int n, input bit bad_id);
    int a0;
    int r0;
    a0 = n_app;
    r0 = n_ref;
    host_frame_source_i.send_request(8'h01, 24'h00003C, 16'h0001, 16'h003C, 16'h003C, 16'h012C, n, bad_id);
    repeat (10) @(posedge clk_in);
    #1;
    check_value(n_app + n_ref - a0 - r0, 0);
  endtask

  task automatic do_reset;
    @(posedge clk_in);
    reset_in <= 1'b1;
    repeat (5) @(posedge clk_in);
    reset_in <= 1'b0;
    e_red  = 1'b0;
    e_dem  = 1'b0;
    e_wake = 24'h000001;
    e_srch = 16'h0078;
    e_off  = 16'h001E;
    e_on   = 16'h00C8;
    @(posedge clk_in);
    #1;
    check_state(1'b1);
    check_value(uart_bps_out, 24'h0012C0);
    check_value(uart_data_bits_out, 4'h8);
    check_value({uart_parity_out, uart_two_stop_out}, 2'h0);
    check_value({twi_multi_master_out, twi_kbps_out}, {1'b1, 24'h000190});
    check_value(spi_max_khz_out, 16'h1A90);
  endtask

  task automatic sleep_test;
    int o0;
    int w0;
    o0 = n_ok;
    w0 = n_wh;
    @(posedge clk_in);
    pending <= 1'b1;
    asleep  <= 1'b1;
    repeat (8) @(posedge clk_in);
    #1;
    check_value(msg_send_enable_out, 1'b0);
    check_value(n_wh - w0, 1);
    check_value(n_ok - o0, 0);
    apply(8'h01, 24'h00000A, 16'h0001, 16'h0078, 16'h001E, 16'h00C8, 1'b0);
    @(posedge clk_in);
    asleep <= 1'b0;
    repeat (8) @(posedge clk_in);
    #1;
    check_value(msg_send_enable_out, 1'b1);
    check_value(n_ok - o0, 1);
    @(posedge clk_in);
    pending <= 1'b0;
    repeat (5) @(posedge clk_in);
    #1;
    check_value(msg_send_enable_out, 1'b0);
  endtask

  initial
  begin
    void'($urandom(6191));
    do_reset();
    apply(8'h01, 24'h000006, 16'h0000, 16'h0005, 16'h0005, 16'h0005, 1'b1);
    foreach (rates[i])
      apply({7'h00, i[0]}, rates[i], 16'h0001, 16'h0078, 16'h001E, ons[i], 1'b1);
    apply(8'h01, 24'h00000A, 16'h0005, 16'h002C, 16'h002D, 16'h00C8, 1'b1);
    apply(8'h01, 24'h00000A, 16'h0001, 16'h002C, 16'h002D, 16'h00C8, 1'b1);
    apply(8'h02, 24'h00003C, 16'h0001, 16'h0010, 16'h0010, 16'h0190, 1'b0);
    apply(8'hFF, 24'h00003C, 16'h0005, 16'h0010, 16'h0010, 16'h0190, 1'b0);
    send_dud(42, 1'b1);
    send_dud(20, 1'b0);
    // a whole valid frame while the enable is low must leave no trace
    clk_en <= 1'b0;
    send_dud(42, 1'b0);
    clk_en <= 1'b1;
    check_state(1'b1);
    apply(8'h00, 24'h000258, 16'h0001, 16'h0011, 16'h0022, 16'h0258, 1'b1);
    repeat (40)
      apply(8'($urandom % 2), rand_rate(), {13'h0000, 1'($urandom % 2), 2'h1}, 16'($urandom % 60000),
            16'($urandom % 60000), 16'($urandom % 1000), 1'b1);
    sleep_test();
    do_reset();
    tally_and_finish();
  end
endmodule
